// *** rtl/fbrm_regs.vh ***
// Constants for the flag branch and register move decoder
`ifndef FBRM_REGS_VH
`define FBRM_REGS_VH
// Status register bit positions
`define FBRM_STATUS_V 3
`define FBRM_STATUS_I 7
`define FBRM_STATUS_WIDTH 8
// Opcode fields and patterns
`define FBRM_OPC_BRANCH_MASK 16'hFC00
`define FBRM_OPC_BRANCH_SET 16'hF000
`define FBRM_OPC_BRANCH_CLEAR 16'hF400
`define FBRM_OPC_COPY_MASK 16'hFC00
`define FBRM_OPC_COPY 16'h2C00
`define FBRM_OPC_PAIR_MASK 16'hFF00
`define FBRM_OPC_PAIR 16'h0100
`define FBRM_PC_STEP 16'h0001
// Instruction field positions
`define FBRM_FLD_SEL 2:0
`define FBRM_FLD_OFFSET 9:3
`define FBRM_FLD_OFFSET_SIGN 9
`define FBRM_OFFSET_WIDTH 7
`define FBRM_FLD_COPY_DST 8:4
`define FBRM_FLD_COPY_SRC_HI 9
`define FBRM_FLD_COPY_SRC_LO 3:0
`define FBRM_FLD_PAIR_DST 7:4
`define FBRM_FLD_PAIR_SRC 3:0
// Cycle counts
`define FBRM_CYC_TAKEN 2'h2
`define FBRM_CYC_PLAIN 2'h1
`endif

// *** rtl/fbrm_core.v ***
// Flag branch and register copy execution slice of an 8-bit core
`timescale 1ns/1ns
`include "fbrm_regs.vh"

module fbrm_core #(
  parameter PC_WIDTH = 16
)(
  input wire clk,
  input wire reset,
  input wire instrValid,
  input wire [15:0] instrWord,
  input wire [PC_WIDTH-1:0] pcIn,
  input wire [7:0] statusRegister,
  output reg [PC_WIDTH-1:0] pcNext_q,
  output reg pcLoad_q,
  output reg busy_q,
  output reg done_q,
  output reg [1:0] cycles_q,
  output reg [4:0] rfReadA_q,
  output reg [4:0] rfWriteAddr_q,
  output reg rfWriteEn_q,
  output reg rfPairWrite_q,
  output reg [7:0] rfWriteLo_q,
  output reg [7:0] rfWriteHi_q,
  output reg flagsWrite_q,
  input wire [7:0] sourceRegister,
  input wire [7:0] sourceRegisterHi
);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_TAKEN = 1'b1;

  reg state_q;
  reg state_d;
  wire isBranchSet;
  wire isBranchClr;
  wire isCopy;
  wire isPair;
  wire [2:0] flagSel;
  wire [`FBRM_STATUS_WIDTH-1:0] flagPick;
  wire flagBit;
  wire takeBranch;
  wire [PC_WIDTH-1:0] offsetExt;
  wire [PC_WIDTH-1:0] target;
  wire [4:0] copyDst;
  wire [4:0] copySrc;
  wire [4:0] pairDst;
  wire [4:0] pairSrc;

  assign isBranchSet = (instrWord & `FBRM_OPC_BRANCH_MASK) == `FBRM_OPC_BRANCH_SET;
  assign isBranchClr = (instrWord & `FBRM_OPC_BRANCH_MASK) == `FBRM_OPC_BRANCH_CLEAR;
  assign isCopy = (instrWord & `FBRM_OPC_COPY_MASK) == `FBRM_OPC_COPY;
  assign isPair = (instrWord & `FBRM_OPC_PAIR_MASK) == `FBRM_OPC_PAIR;
  // Flag select: bits 2:0 pick any of the 8 status bits, such as V for overflow or I for interrupt
  assign flagSel = instrWord[`FBRM_FLD_SEL];
  // Set form needs bit 1, clear form needs bit 0
  assign takeBranch = (isBranchSet & flagBit) | (isBranchClr & ~flagBit);
  assign offsetExt = {{(PC_WIDTH-`FBRM_OFFSET_WIDTH){instrWord[`FBRM_FLD_OFFSET_SIGN]}},
    instrWord[`FBRM_FLD_OFFSET]};
  assign target = pcIn + offsetExt + `FBRM_PC_STEP;
  assign copyDst = instrWord[`FBRM_FLD_COPY_DST];
  assign copySrc = {instrWord[`FBRM_FLD_COPY_SRC_HI], instrWord[`FBRM_FLD_COPY_SRC_LO]};
  assign pairDst = {instrWord[`FBRM_FLD_PAIR_DST], 1'b0};
  assign pairSrc = {instrWord[`FBRM_FLD_PAIR_SRC], 1'b0};

  // ----------------------------------------
  // Status bit select
  // ----------------------------------------
  // One match term per status bit, ORed into the tested flag
  genvar bitIdx;
  generate
    for (bitIdx = 0; bitIdx < `FBRM_STATUS_WIDTH; bitIdx = bitIdx + 1)
    begin : gFlagPick
      localparam [2:0] BIT_CODE = bitIdx;
      assign flagPick[bitIdx] = statusRegister[bitIdx] & (flagSel == BIT_CODE);
    end
  endgenerate

  assign flagBit = |flagPick;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (instrValid && takeBranch)
        begin
          state_d = ST_TAKEN;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // Program counter path
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (reset)
    begin
      pcNext_q <= {PC_WIDTH{1'b0}};
      pcLoad_q <= 1'b0;
    end
    else
    begin
      // Second cycle of a taken branch loads the target
      pcLoad_q <= (state_q == ST_TAKEN);
      if (state_q == ST_IDLE && instrValid)
      begin
        if (takeBranch)
        begin
          pcNext_q <= target;
        end
        else
        begin
          pcNext_q <= pcIn + `FBRM_PC_STEP;
        end
      end
    end
  end

  // ----------------------------------------
  // Completion and cycle count
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (reset)
    begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      cycles_q <= 2'h0;
      flagsWrite_q <= 1'b0;
    end
    else
    begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      // No instruction of this slice alters the status register
      flagsWrite_q <= 1'b0;
      if (state_q == ST_TAKEN)
      begin
        done_q <= 1'b1;
        cycles_q <= `FBRM_CYC_TAKEN;
      end
      else if (instrValid)
      begin
        if (takeBranch)
        begin
          busy_q <= 1'b1;
        end
        else
        begin
          done_q <= 1'b1;
          cycles_q <= `FBRM_CYC_PLAIN;
        end
      end
    end
  end

  // ----------------------------------------
  // Register file write port
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (reset)
    begin
      rfReadA_q <= 5'h00;
      rfWriteAddr_q <= 5'h00;
      rfWriteEn_q <= 1'b0;
      rfPairWrite_q <= 1'b0;
      rfWriteLo_q <= 8'h00;
      rfWriteHi_q <= 8'h00;
    end
    else
    begin
      rfWriteEn_q <= 1'b0;
      rfPairWrite_q <= 1'b0;
      if (state_q == ST_IDLE && instrValid)
      begin
        rfReadA_q <= isPair ? pairSrc : copySrc;
        if (isCopy)
        begin
          rfWriteAddr_q <= copyDst;
          rfWriteLo_q <= sourceRegister;
          rfWriteEn_q <= 1'b1;
        end
        else if (isPair)
        begin
          rfWriteAddr_q <= pairDst;
          rfWriteLo_q <= sourceRegister;
          rfWriteHi_q <= sourceRegisterHi;
          rfWriteEn_q <= 1'b1;
          rfPairWrite_q <= 1'b1;
        end
      end
    end
  end

endmodule

// *** dv/fbrm_core_sva.sv ***
// Checker for the branch and copy slice
`timescale 1ns/1ns
module fbrm_core_sva #(
  parameter PC_WIDTH = 16
)(
  input wire clk,
  input wire reset,
  input wire instrValid,
  input wire [15:0] instrWord,
  input wire [PC_WIDTH-1:0] pcIn,
  input wire [7:0] statusRegister,
  input wire [PC_WIDTH-1:0] pcNext_q,
  input wire busy_q,
  input wire pcLoad_q,
  input wire done_q,
  input wire [1:0] cycles_q,
  input wire rfWriteEn_q,
  input wire rfPairWrite_q,
  input wire flagsWrite_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire a = instrValid && !busy_q;
  wire b = a && instrWord[15:11] == 5'h1E;
  wire t = b && statusRegister[instrWord[2:0]] == !instrWord[10];
  wire c = a && instrWord[15:10] == 6'h0B;
  wire p = a && instrWord[15:8] == 8'h01;
  wire [PC_WIDTH-1:0] seqPc = pcIn + {{(PC_WIDTH-1){1'b0}}, 1'b1};
  wire [PC_WIDTH-1:0] jumpPc = seqPc + {{(PC_WIDTH-7){instrWord[9]}}, instrWord[9:3]};
  AST_PT: assert property (t |=> pcNext_q == $past(jumpPc)) else $error("pt");
  AST_PS: assert property (a && !t |=> pcNext_q == $past(seqPc)) else $error("ps");
  AST_TK: assert property (t |=> busy_q ##1 cycles_q == 2'h2) else $error("tk");
  AST_NT: assert property (b && !t |=> done_q && cycles_q == 2'h1) else $error("nt");
  AST_LD: assert property (busy_q |=> pcLoad_q && !busy_q) else $error("ld");
  AST_BW: assert property (b |=> !rfWriteEn_q) else $error("bw");
  AST_CP: assert property (c |=> rfWriteEn_q && !rfPairWrite_q) else $error("cp");
  AST_PR: assert property (p |=> rfWriteEn_q && rfPairWrite_q) else $error("pr");
  AST_FL: assert property (!flagsWrite_q) else $error("fl");
  AST_IR: assert property (!a |=> !done_q || pcLoad_q) else $error("ir");
  cover property (t);
  cover property (b && !t);
  cover property (p);
  cover property (c);
endmodule
bind fbrm_core fbrm_core_sva #(
  .PC_WIDTH(PC_WIDTH)
) chk (
  .clk(clk),
  .reset(reset),
  .instrValid(instrValid),
  .instrWord(instrWord),
  .pcIn(pcIn),
  .statusRegister(statusRegister),
  .pcNext_q(pcNext_q),
  .busy_q(busy_q),
  .pcLoad_q(pcLoad_q),
  .done_q(done_q),
  .cycles_q(cycles_q),
  .rfWriteEn_q(rfWriteEn_q),
  .rfPairWrite_q(rfPairWrite_q),
  .flagsWrite_q(flagsWrite_q)
);

// *** dv/fbrm_core_test.sv ***
// Bench for the branch and copy slice
`timescale 1ns/1ns
module fbrm_core_test;
  reg clk = 0, reset = 1, instrValid = 0, t, b;
  reg [15:0] instrWord = 16'h0000, pcIn = 16'h0000;
  reg [7:0] statusRegister = 8'h00, sourceRegister = 8'h00, sourceRegisterHi = 8'h00;
  wire [15:0] pcNext_q;
  wire [7:0] rfWriteLo_q, rfWriteHi_q;
  wire [4:0] rfReadA_q, rfWriteAddr_q;
  wire [1:0] cycles_q;
  wire pcLoad_q, busy_q, done_q, rfWriteEn_q, rfPairWrite_q, flagsWrite_q;
  integer err_count = 0, checked = 0, i;
  reg [31:0] r = 86141;
  fbrm_core uut (
    .clk(clk),
    .reset(reset),
    .instrValid(instrValid),
    .instrWord(instrWord),
    .pcIn(pcIn),
    .statusRegister(statusRegister),
    .pcNext_q(pcNext_q),
    .pcLoad_q(pcLoad_q),
    .busy_q(busy_q),
    .done_q(done_q),
    .cycles_q(cycles_q),
    .rfReadA_q(rfReadA_q),
    .rfWriteAddr_q(rfWriteAddr_q),
    .rfWriteEn_q(rfWriteEn_q),
    .rfPairWrite_q(rfPairWrite_q),
    .rfWriteLo_q(rfWriteLo_q),
    .rfWriteHi_q(rfWriteHi_q),
    .flagsWrite_q(flagsWrite_q),
    .sourceRegister(sourceRegister),
    .sourceRegisterHi(sourceRegisterHi)
  );
  always #20 clk = ~clk;
  function [31:0] nx(input [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [15:0] jump(input [15:0] w, input [15:0] pc);
    jump = pc + {{9{w[9]}}, w[9:3]} + 16'h0001;
  endfunction
  function [4:0] dst(input [15:0] w);
    dst = w[15:8] == 8'h01 ? {w[7:4], 1'b0} : w[8:4];
  endfunction
  function [4:0] src(input [15:0] w);
    src = w[15:8] == 8'h01 ? {w[3:0], 1'b0} : {w[9], w[3:0]};
  endfunction
  task k(input [31:0] n, input [15:0] e, input [15:0] s);
    checked = checked + 1;
    if (s !== e)
    begin
      $display("BAD %s %h %h", n, e, s);
      err_count = err_count + 1;
    end
  endtask
  task summarize;
    $display("%0d of %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task run(input [15:0] w, input [7:0] sr);
    b = w[15:11] == 5'h1E;
    t = b && sr[w[2:0]] == !w[10];
    r = nx(r);
    {instrValid, instrWord, pcIn, statusRegister} = {1'b1, w, r[15:0], sr};
    {sourceRegister, sourceRegisterHi} = r[31:16];
    @(negedge clk);
    k("pc", t ? jump(w, pcIn) : pcIn + 16'h0001, pcNext_q);
    k("busy", t, busy_q);
    if (t)
    begin
      instrValid = 0;
      @(negedge clk);
    end
    k("cyc", {t, !t}, cycles_q);
    k("load", t, pcLoad_q);
    k("done", 1'b1, done_q);
    k("flag", 1'b0, flagsWrite_q);
    k("wen", !b, rfWriteEn_q);
    k("pair", w[15:8] == 8'h01, rfPairWrite_q);
    if (!b)
    begin
      k("lo", sourceRegister, rfWriteLo_q);
      k("dst", dst(w), rfWriteAddr_q);
      k("src", src(w), rfReadA_q);
    end
    if (w[15:8] == 8'h01)
      k("hi", sourceRegisterHi, rfWriteHi_q);
  endtask
  initial
  begin
    repeat (3) @(negedge clk);
    reset = 0;
    run(16'hF1FB, 8'h08);
    run(16'hF607, 8'h00);
    run(16'hF40B, 8'h08);
    run(16'hF3FF, 8'h80);
    run(16'h2DF5, 8'h00);
    run(16'h01E4, 8'h00);
    reset = 1;
    instrValid = 0;
    @(negedge clk);
    k("rpc", 16'h0000, pcNext_q);
    k("rdn", 1'b0, done_q);
    reset = 0;
    for (i = 0; i < 300; i = i + 1)
      run(r[2] ? (r[1] ? {8'h01, r[10:3]} : {6'h0B, r[12:3]})
        : {5'h1E, r[0], r[12:6], r[1], 2'h3}, r[31:24]);
    summarize;
  end
  initial
  begin
    #100000 err_count = err_count + 1;
    summarize;
  end
endmodule
